// ---- tag_activation_pkg.sv ----
// constants and types shared by the tag activation state machine
package tag_activation_pkg;

  // *********************************************************************
  // command codes and answers
  // *********************************************************************
  localparam logic [7:0] CMD_REQA        = 8'h26;
  localparam logic [7:0] CMD_WUPA        = 8'h52;
  localparam logic [7:0] CMD_HLTA        = 8'h50;
  localparam logic [7:0] CMD_SEL_CL1     = 8'h93;
  localparam logic [7:0] CMD_SEL_CL2     = 8'h95;
  localparam logic [7:0] NVB_ANTICOLL    = 8'h20;
  localparam logic [7:0] NVB_SELECT      = 8'h70;
  localparam logic [7:0] CASCADE_TAG     = 8'h88;
  localparam logic [7:0] SAK_INCOMPLETE  = 8'h04;
  localparam logic [7:0] SAK_COMPLETE    = 8'h00;
  localparam logic [7:0] PASSWORD_AUTHENTICATE_CMD_CODE   = 8'h1B;
  localparam logic [7:0] CMD_READ        = 8'h30;
  localparam logic [7:0] ATQA_LO         = 8'h44;
  localparam logic [7:0] ATQA_HI         = 8'h00;
  localparam logic [3:0] NAK_CODE        = 4'h0;

  // *********************************************************************
  // frame and crc
  // *********************************************************************
  localparam logic [15:0] CRC_INIT       = 16'h6363;
  localparam logic [15:0] CRC_POLY_REFL  = 16'h8408;
  localparam int          SHORT_BITS     = 7;
  localparam int          UID_BYTES      = 7;
  localparam int          PWD_BITS       = 32;
  localparam int          PAGE_BYTES     = 4;
  localparam int          FRAME_MAX      = 9;

  // symbol codes from the demodulator
  localparam logic [1:0] SYM_ZERO        = 2'b00;
  localparam logic [1:0] SYM_ONE         = 2'b01;
  localparam logic [1:0] SYM_NONE        = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_READY1   = 3'b001,
    ST_READY2   = 3'b010,
    ST_ACTIVE   = 3'b011,
    ST_UNLOCKED = 3'b100,
    ST_HALT     = 3'b101
  } tag_state_t;

endpackage

// ---- tag_activation_fsm.sv ----
// frame checking and activation state machine of a contactless tag
`timescale 1ns/1ns
`default_nettype none

module tag_activation_fsm
  import tag_activation_pkg::*;
#(
  parameter logic [55:0] UID         = 56'h0001_0203_0405_06,
  parameter logic [31:0] PASSWORD    = 32'hFFFF_FFFF,
  parameter logic [15:0] ACK_VALUE   = 16'h0000,
  parameter logic [7:0]  AUTH_START  = 8'hFF
)(
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  // demodulated symbol stream
  input  wire logic       sym_valid_i,
  input  wire logic [1:0] sym_code_i,
  input  wire logic       frame_end_i,
  // response byte stream towards the modulator
  output logic            tx_valid_o,
  output logic [7:0]      tx_data_o,
  output logic            tx_last_o,
  output logic [3:0]      tx_bits_o,
  input  wire logic       tx_ready_i,
  // memory read port
  output logic            mem_rd_o,
  output logic [7:0]      mem_page_o,
  input  wire logic [31:0] mem_data_i,
  // status
  output tag_activation_pkg::tag_state_t state_o,
  output logic            frame_err_o
);
  import tag_activation_pkg::*;

  // *********************************************************************
  // input synchronisers
  // *********************************************************************
  logic       sv_m_q, sv_q, fe_m_q, fe_q;
  logic [1:0] sc_m_q, sc_q;
  always_ff @(posedge ref_clk_i)
  begin
    sv_m_q <= sym_valid_i;
    sv_q   <= sv_m_q;
    sc_m_q <= sym_code_i;
    sc_q   <= sc_m_q;
    fe_m_q <= frame_end_i;
    fe_q   <= fe_m_q;
  end
  // strobes are level-held; act on the rising edge of the synced copy
  logic sv_d1_q, fe_d1_q;
  always_ff @(posedge ref_clk_i)
  begin
    sv_d1_q <= sv_q;
    fe_d1_q <= fe_q;
  end
  wire sym_stb = sv_q & ~sv_d1_q;
  wire end_stb = fe_q & ~fe_d1_q;

  // *********************************************************************
  // receive deframer
  // *********************************************************************
  logic       started_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [3:0] nbytes_q;
  logic [7:0] rx_q [FRAME_MAX];
  logic       par_err_q, sym_err_q;
  logic [15:0] crc_q;
  logic [3:0] short_bits_q;

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1);
    return r;
  endfunction

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || end_stb)
    begin
      started_q    <= 1'b0;
      bit_q        <= 4'h0;
      nbytes_q     <= 4'h0;
      par_err_q    <= 1'b0;
      sym_err_q    <= 1'b0;
      crc_q        <= CRC_INIT;
      short_bits_q <= 4'h0;
      sh_q         <= 8'h00;
    end
    else if (sym_stb)
    begin
      if (!started_q)
      begin
        if (sc_q == SYM_ZERO)
          started_q <= 1'b1;
        else
          sym_err_q <= 1'b1;
      end
      else if (sc_q == SYM_NONE)
        sym_err_q <= 1'b1;
      else if (bit_q < 4'd8)
      begin
        sh_q  <= {sc_q[0], sh_q[7:1]};
        bit_q <= bit_q + 4'd1;
        short_bits_q <= bit_q + 4'd1;
      end
      else
      begin
        if (sc_q[0] == ^sh_q)
          par_err_q <= 1'b1;
        if (nbytes_q < 4'(FRAME_MAX))
        begin
          rx_q[nbytes_q] <= sh_q;
          nbytes_q       <= nbytes_q + 4'd1;
        end
        else
          sym_err_q <= 1'b1;
        crc_q <= crc_byte(crc_q, sh_q);
        bit_q <= 4'h0;
        short_bits_q <= 4'h0;
      end
    end
  end

  // short frame: exactly seven data bits, no parity
  wire is_short = (nbytes_q == 4'd0) && (short_bits_q == 4'(SHORT_BITS));
  wire short_cmd_ok = is_short && !sym_err_q;
  wire [6:0] short_cmd = sh_q[7:1];
  // a full frame: whole bytes only; crc_ok adds crc residue zero
  wire std_ok = !sym_err_q && !par_err_q && bit_q == 4'h0
              && nbytes_q >= 4'd1;
  wire crc_ok = std_ok && nbytes_q >= 4'd3 && crc_q == 16'h0000;

  // *********************************************************************
  // transmit staging and two-entry output buffer
  // *********************************************************************
  logic [7:0] msg_q [FRAME_MAX];
  logic [3:0] msg_len_q, msg_idx_q;
  logic [3:0] msg_bits_q;
  logic       msg_busy_q;

  logic [7:0] buf_data_q [2];
  logic       buf_last_q [2];
  logic       wr_ptr_q, rd_ptr_q;
  logic [1:0] cnt_q;
  wire buf_full  = cnt_q == 2'd2;
  wire push      = msg_busy_q && !buf_full;
  wire pop       = (cnt_q != 2'd0) && tx_ready_i;

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      cnt_q    <= 2'd0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        buf_data_q[wr_ptr_q] <= msg_q[msg_idx_q];
        buf_last_q[wr_ptr_q] <= (msg_idx_q + 4'd1 == msg_len_q);
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
  assign tx_valid_o = cnt_q != 2'd0;
  assign tx_data_o  = buf_data_q[rd_ptr_q];
  assign tx_last_o  = buf_last_q[rd_ptr_q];
  assign tx_bits_o  = msg_bits_q;

  // *********************************************************************
  // command decode and state machine
  // *********************************************************************
  tag_state_t state_q;
  logic       from_halt_q;
  logic       rd_wait_q;
  logic [7:0] rd_page_q;

  wire [55:0] uid = UID;
  // level one: cascade tag plus uid bytes 0..2; level two: bytes 3..6
  wire [7:0] cl1 [4] = '{CASCADE_TAG, uid[55:48], uid[47:40], uid[39:32]};
  wire [7:0] cl2 [4] = '{uid[31:24], uid[23:16], uid[15:8], uid[7:0]};
  wire is_sel   = crc_ok && nbytes_q == 4'd9 && rx_q[1] == NVB_SELECT;
  wire is_anti  = std_ok && nbytes_q == 4'd2 && rx_q[1] == NVB_ANTICOLL;
  wire cl1_hit  = rx_q[2] == cl1[0] && rx_q[3] == cl1[1]
               && rx_q[4] == cl1[2] && rx_q[5] == cl1[3];
  wire cl2_hit  = rx_q[2] == cl2[0] && rx_q[3] == cl2[1]
               && rx_q[4] == cl2[2] && rx_q[5] == cl2[3];
  wire [31:0] pwd_rx = {rx_q[4], rx_q[3], rx_q[2], rx_q[1]};
  wire wake  = short_cmd_ok && short_cmd == CMD_WUPA[6:0];
  wire req   = short_cmd_ok && short_cmd == CMD_REQA[6:0];
  wire hlta  = crc_ok && nbytes_q == 4'd4 && rx_q[0] == CMD_HLTA;
  wire wait_st = from_halt_q ? 1'b1 : 1'b0;
  tag_state_t wait_state;
  assign wait_state = wait_st ? ST_HALT : ST_IDLE;

  task automatic send1(input logic [7:0] b, input logic [3:0] bits);
    msg_q[0]   <= b;
    msg_len_q  <= 4'd1;
    msg_bits_q <= bits;
    msg_idx_q  <= 4'd0;
    msg_busy_q <= 1'b1;
  endtask

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      state_q     <= ST_IDLE;
      from_halt_q <= 1'b0;
      msg_busy_q  <= 1'b0;
      msg_idx_q   <= 4'd0;
      msg_len_q   <= 4'd0;
      msg_bits_q  <= 4'd8;
      rd_wait_q   <= 1'b0;
      rd_page_q   <= 8'h00;
      frame_err_o <= 1'b0;
    end
    else
    begin
      frame_err_o <= 1'b0;
      if (push)
      begin
        msg_idx_q <= msg_idx_q + 4'd1;
        if (msg_idx_q + 4'd1 == msg_len_q)
          msg_busy_q <= 1'b0;
      end
      if (rd_wait_q)
      begin
        // page bytes low first: byte 0 of the page leads
        for (int i = 0; i < PAGE_BYTES; i++)
          msg_q[i] <= mem_data_i[8*i +: 8];
        msg_len_q  <= 4'(PAGE_BYTES);
        msg_bits_q <= 4'd8;
        msg_idx_q  <= 4'd0;
        msg_busy_q <= 1'b1;
        rd_wait_q  <= 1'b0;
      end
      // only a finished reader frame triggers anything
      if (end_stb && !msg_busy_q)
      begin
        case (state_q)
          ST_IDLE:
          begin
            if (req || wake)
            begin
              state_q     <= ST_READY1;
              from_halt_q <= 1'b0;
              msg_q[0] <= ATQA_LO;
              msg_q[1] <= ATQA_HI;
              msg_len_q <= 4'd2;
              msg_bits_q <= 4'd8;
              msg_idx_q <= 4'd0;
              msg_busy_q <= 1'b1;
            end
            else
              frame_err_o <= 1'b1;
          end
          ST_READY1, ST_READY2:
          begin
            if (std_ok && rx_q[0] == ((state_q == ST_READY1)
                ? CMD_SEL_CL1 : CMD_SEL_CL2) && is_anti)
            begin
              for (int i = 0; i < 4; i++)
                msg_q[i] <= (state_q == ST_READY1) ? cl1[i] : cl2[i];
              msg_q[4] <= (state_q == ST_READY1)
                        ? cl1[0] ^ cl1[1] ^ cl1[2] ^ cl1[3]
                        : cl2[0] ^ cl2[1] ^ cl2[2] ^ cl2[3];
              msg_len_q  <= 4'd5;
              msg_bits_q <= 4'd8;
              msg_idx_q  <= 4'd0;
              msg_busy_q <= 1'b1;
            end
            else if (is_sel && state_q == ST_READY1
                     && rx_q[0] == CMD_SEL_CL1 && cl1_hit)
            begin
              state_q <= ST_READY2;
              send1(SAK_INCOMPLETE, 4'd8);
            end
            else if (is_sel && state_q == ST_READY2
                     && rx_q[0] == CMD_SEL_CL2 && cl2_hit)
            begin
              state_q <= ST_ACTIVE;
              send1(SAK_COMPLETE, 4'd8);
            end
            else
            begin
              state_q     <= wait_state;
              frame_err_o <= 1'b1;
            end
          end
          ST_ACTIVE, ST_UNLOCKED:
          begin
            if (hlta)
              state_q <= ST_HALT;
            else if (crc_ok && nbytes_q == 4'd7 && rx_q[0] == PASSWORD_AUTHENTICATE_CMD_CODE
                     && state_q == ST_ACTIVE && pwd_rx == PASSWORD)
            begin
              state_q    <= ST_UNLOCKED;
              msg_q[0]   <= ACK_VALUE[7:0];
              msg_q[1]   <= ACK_VALUE[15:8];
              msg_len_q  <= 4'd2;
              msg_bits_q <= 4'd8;
              msg_idx_q  <= 4'd0;
              msg_busy_q <= 1'b1;
            end
            else if (crc_ok && nbytes_q == 4'd4 && rx_q[0] == CMD_READ
                     && (rx_q[1] < AUTH_START
                         || state_q == ST_UNLOCKED))
            begin
              rd_page_q <= rx_q[1];
              rd_wait_q <= 1'b1;
            end
            else
            begin
              state_q     <= wait_state;
              frame_err_o <= 1'b1;
              if (crc_ok)
                send1({4'h0, NAK_CODE}, 4'd4);
            end
          end
          ST_HALT:
          begin
            if (wake)
            begin
              state_q     <= ST_READY1;
              from_halt_q <= 1'b1;
              msg_q[0] <= ATQA_LO;
              msg_q[1] <= ATQA_HI;
              msg_len_q <= 4'd2;
              msg_bits_q <= 4'd8;
              msg_idx_q <= 4'd0;
              msg_busy_q <= 1'b1;
            end
            else
              frame_err_o <= 1'b1;
          end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  assign mem_rd_o   = rd_wait_q;
  assign mem_page_o = rd_page_q;
  assign state_o    = state_q;

endmodule // tag_activation_fsm

`default_nettype wire

// ---- tag_activation_checker.sv ----
// assertions on the ports of the tag activation state machine
`timescale 1ns/1ns
`default_nettype none
module tag_activation_checker
  import tag_activation_pkg::*;
(
  input wire logic                           ref_clk_i,
  input wire logic                           reset_i,
  input wire logic                           tx_valid_o,
  input wire logic [7:0]                     tx_data_o,
  input wire logic                           tx_last_o,
  input wire logic                           tx_ready_i,
  input wire logic                           mem_rd_o,
  input wire tag_activation_pkg::tag_state_t state_o,
  input wire logic                           frame_err_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // *****
  // state and stream relations
  // *****
  property p_reset_idle;
    disable iff (1'b0)
    reset_i |=> state_o == ST_IDLE && !tx_valid_o && !frame_err_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("not idle and quiet after reset");
  // a stalled byte must not move or the stream order breaks
  property p_tx_hold;
    tx_valid_o && !tx_ready_i
      |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("stalled response byte changed");
  property p_err_pulse;
    frame_err_o |=> !frame_err_o;
  endproperty
  a_err_pulse: assert property (p_err_pulse)
    else $error("frame error longer than one cycle");
  property p_idle_exit;
    state_o == ST_IDLE |=> state_o inside {ST_IDLE, ST_READY1};
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("illegal exit from idle");
  property p_halt_exit;
    state_o == ST_HALT |=> state_o inside {ST_HALT, ST_READY1};
  endproperty
  a_halt_exit: assert property (p_halt_exit)
    else $error("illegal exit from halt");
  property p_ready2_entry;
    state_o == ST_READY2 && $past(state_o) != ST_READY2
      |-> $past(state_o) == ST_READY1;
  endproperty
  a_ready2_entry: assert property (p_ready2_entry)
    else $error("second ready entered from wrong state");
  property p_active_entry;
    state_o == ST_ACTIVE && $past(state_o) != ST_ACTIVE
      |-> $past(state_o) == ST_READY2;
  endproperty
  a_active_entry: assert property (p_active_entry)
    else $error("active entered from wrong state");
  property p_unlock_entry;
    state_o == ST_UNLOCKED && $past(state_o) != ST_UNLOCKED
      |-> $past(state_o) == ST_ACTIVE;
  endproperty
  a_unlock_entry: assert property (p_unlock_entry)
    else $error("unlocked entered from wrong state");
  property p_read_state;
    mem_rd_o |-> state_o inside {ST_ACTIVE, ST_UNLOCKED};
  endproperty
  a_read_state: assert property (p_read_state)
    else $error("memory read outside selected states");
endmodule // tag_activation_checker

bind tag_activation_fsm tag_activation_checker u_chk (
  .ref_clk_i (ref_clk_i), .reset_i (reset_i), .tx_valid_o (tx_valid_o),
  .tx_data_o (tx_data_o), .tx_last_o (tx_last_o), .tx_ready_i (tx_ready_i),
  .mem_rd_o (mem_rd_o), .state_o (state_o), .frame_err_o (frame_err_o)
);
`default_nettype wire

// ---- reader_model.sv ----
// reader, modulator and page memory model facing the tag
`timescale 1ns/1ns
`default_nettype none
module reader_model
  import tag_activation_pkg::*;
(
  input  wire logic        clk_i,
  output logic             sym_valid_o,
  output logic [1:0]       sym_code_o,
  output logic             frame_end_o,
  input  wire logic        tx_valid_i,
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        tx_last_i,
  output logic             tx_ready_o,
  input  wire logic        mem_rd_i,
  input  wire logic [7:0]  mem_page_i,
  output logic [31:0]      mem_data_o
);
  logic [7:0]  rx_q [$];
  int          n_last;
  logic [15:0] stall_q = 16'hace1;
  initial
  begin
    sym_valid_o = 1'b0;
    sym_code_o = 2'b11;
    frame_end_o = 1'b0;
    tx_ready_o = 1'b0;
  end
  // page data answers in the same cycle as the read strobe, so the tag
  // samples it on the edge that closes its one-cycle read pulse
  assign mem_data_o = {mem_page_i ^ 8'hc3, mem_page_i + 8'h40,
                       ~mem_page_i, mem_page_i};
  // *****
  // symbol link
  // *****
  task automatic sym(input logic [1:0] c);
    @(posedge clk_i);
    #1 sym_code_o = c;
    @(posedge clk_i);
    #1 sym_valid_o = 1'b1;
    repeat (4) @(posedge clk_i);
    // released code line shows garbage, not the last symbol
    #1 sym_valid_o = 1'b0;
    sym_code_o = ~c;
  endtask
  // bad: 1 parity slip on first byte, 2 crc slip
  task automatic send(input logic [7:0] q [$], input bit crc, input int bad);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
    end
    c[0] = c[0] ^ (bad == 2);
    if (crc) q = {q, c[7:0], c[15:8]};
    rx_q.delete();
    n_last = 0;
    sym(SYM_ZERO);
    if (!crc && q.size() == 1)
      for (int b = 0; b < SHORT_BITS; b++) sym({1'b0, q[0][b]});
    else
      foreach (q[i])
      begin
        for (int b = 0; b < 8; b++) sym({1'b0, q[i][b]});
        sym({1'b0, ~^q[i] ^ (bad == 1 && i == 0)});
      end
    @(posedge clk_i);
    #1 frame_end_o = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 frame_end_o = 1'b0;
  endtask
  always @(posedge clk_i)
  begin
    if (tx_valid_i && tx_ready_o)
    begin
      rx_q.push_back(tx_data_i);
      n_last += tx_last_i;
    end
    stall_q <= {stall_q[14:0], stall_q[15] ^ stall_q[13] ^ stall_q[12]};
    #1 tx_ready_o = stall_q[1] | stall_q[4];
  end
endmodule // reader_model
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the tag activation state machine
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import tag_activation_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        sym_valid, frame_end, tx_valid, tx_last, tx_ready, mem_rd;
  logic        frame_err;
  logic [1:0]  sym_code;
  logic [3:0]  tx_bits;
  logic [7:0]  tx_data, mem_page;
  logic [31:0] mem_data, seed;
  tag_state_t  st;
  int          fail_count, n_compared, cyc, n_err, n_rd, e;
  tag_activation_fsm #(.UID(56'h11_2233_4433_2211), .PASSWORD(32'h1234_5678),
    .ACK_VALUE(16'ha55a), .AUTH_START(8'h10)) u_dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .sym_valid_i(sym_valid),
    .sym_code_i(sym_code), .frame_end_i(frame_end), .tx_valid_o(tx_valid),
    .tx_data_o(tx_data), .tx_last_o(tx_last), .tx_bits_o(tx_bits),
    .tx_ready_i(tx_ready), .mem_rd_o(mem_rd), .mem_page_o(mem_page),
    .mem_data_i(mem_data), .state_o(st), .frame_err_o(frame_err));
  reader_model u_rdr (.clk_i(ref_clk_i), .sym_valid_o(sym_valid),
    .sym_code_o(sym_code), .frame_end_o(frame_end), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .tx_last_i(tx_last), .tx_ready_o(tx_ready),
    .mem_rd_i(mem_rd), .mem_page_i(mem_page), .mem_data_o(mem_data));
  always #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
  begin
    cyc++;
    n_err += frame_err;
    n_rd += mem_rd;
    if (cyc == 60000)
    begin
      fail_count++;
      final_report();
    end
  end
  // *****
  // helpers
  // *****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0000_0000);
  endfunction
  function automatic logic [7:0] eb(input logic [7:0] p, input int i);
    eb = i == 0 ? p : i == 1 ? ~p : i == 2 ? p + 8'h40 : p ^ 8'hc3;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] q [$], input bit crc, input int bad,
                     input int n);
    int w;
    u_rdr.send(q, crc, bad);
    for (w = 0; w < 400 && u_rdr.n_last == 0; w++) @(posedge ref_clk_i);
    repeat (20) @(posedge ref_clk_i);
    if (n >= 0) chk(u_rdr.rx_q.size(), n);
  endtask
  task automatic rd(input logic [7:0] p, input bit ok);
    int r;
    r = n_rd;
    cmd('{CMD_READ, p}, 1, 0, ok ? PAGE_BYTES : 1);
    if (ok)
      for (int i = 0; i < PAGE_BYTES; i++) chk(u_rdr.rx_q[i], eb(p, i));
    chk(n_rd > r, ok);
  endtask
  task automatic activate(input logic [7:0] wake);
    cmd('{wake}, 0, 0, 2);
    chk({u_rdr.rx_q[1], u_rdr.rx_q[0]}, {ATQA_HI, ATQA_LO});
    chk(tx_bits, 4'h8);
    cmd('{CMD_SEL_CL1, NVB_ANTICOLL}, 0, 0, 5);
    chk({u_rdr.rx_q[0], u_rdr.rx_q[4]}, {CASCADE_TAG, 8'h88});
    cmd('{CMD_SEL_CL1, NVB_SELECT, 8'h88, 8'h11, 8'h22, 8'h33, 8'h88}, 1, 0, -1);
    chk({u_rdr.rx_q[0], 5'h00, st}, {SAK_INCOMPLETE, 5'h00, ST_READY2});
    cmd('{CMD_SEL_CL2, NVB_ANTICOLL}, 0, 0, 5);
    chk({u_rdr.rx_q[0], u_rdr.rx_q[1]}, 16'h4433);
    cmd('{CMD_SEL_CL2, NVB_SELECT, 8'h44, 8'h33, 8'h22, 8'h11, 8'h44}, 1, 0, -1);
    chk({u_rdr.rx_q[0], 5'h00, st}, {SAK_COMPLETE, 5'h00, ST_ACTIVE});
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // *****
  // main sequence
  // *****
  initial
  begin
    seed = 32'hc954dfdd;
    repeat (16) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    chk(st, ST_IDLE);
    for (int k = 0; k < 12; k++)
    begin
      seed = lfsr(seed);
      if (seed[6:0] == CMD_REQA[6:0] || seed[6:0] == CMD_WUPA[6:0]) seed[0] = ~seed[0];
      e = n_err;
      cmd('{{1'b0, seed[6:0]}}, 0, 0, 0);
      chk({n_err > e, st}, {1'b1, ST_IDLE});
    end
    activate(CMD_REQA);
    for (int k = 0; k < 3; k++)
    begin
      seed = lfsr(seed);
      rd(seed[7:0] % 8'd13, 1);
    end
    rd(8'h10, 0);
    activate(CMD_REQA);
    cmd('{PASSWORD_AUTHENTICATE_CMD_CODE, 8'h78, 8'h56, 8'h34, 8'h12}, 1, 0, -1);
    chk({u_rdr.rx_q[0], u_rdr.rx_q[1], 5'h00, st}, {16'h5aa5, 5'h00, ST_UNLOCKED});
    rd(8'h10, 1);
    cmd('{CMD_HLTA, 8'h00}, 1, 0, 0);
    chk(st, ST_HALT);
    cmd('{CMD_REQA}, 0, 0, 0);
    chk(st, ST_HALT);
    activate(CMD_WUPA);
    cmd('{CMD_READ, 8'h01}, 1, 2, 0);
    chk(st, ST_HALT);
    activate(CMD_WUPA);
    cmd('{8'h60, 8'h00}, 1, 0, 1);
    chk({u_rdr.rx_q[0][3:0], 1'b0, st}, {NAK_CODE, 1'b0, ST_HALT});
    chk(tx_bits, 4'h4);
    #1 reset_i = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    cmd('{CMD_REQA}, 0, 0, 2);
    cmd('{CMD_SEL_CL1, NVB_ANTICOLL}, 0, 1, 0);
    chk(st, ST_IDLE);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
